// ---- cfe_confine.sv ----
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_confine
  import cfe_pkg::*;
(
  input  wire logic     i_clk,   // Peripheral clock
  input  wire logic     i_rst_n, // Synchronous reset, active low
  input  wire logic     i_cfg,   // Configuration mode
  input  wire cfe_evt_t i_evt,   // Error and frame events
  output cfe_fc_t       o_fc,    // Error counts
  output logic          o_recov  // Pulse: bus-off recovery done
);
  logic [8:0] tec_reg;   // Transmit count, ninth bit is bus-off
  logic [7:0] rec_reg;   // Receive count
  logic [7:0] runs_reg;  // Recessive runs seen while bus-off
  logic       recov_reg; // Recovery pulse
  logic       boff;      // Bus-off state
  logic       recov_now; // Last run of recovery seen
  logic [8:0] rec_sum;   // Receive count plus step

  assign boff      = tec_reg > `CFE_TEC_BOFF;
  assign recov_now = boff && i_evt.idle11 && (runs_reg == `CFE_RECOV_N);
  assign rec_sum   = {1'b0, rec_reg} + (i_evt.rx_sev ? `CFE_RX_SEV : `CFE_RX_ONE);

  // Transmit count; frozen while bus-off until recovery ends
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_cfg || recov_now) begin
      tec_reg <= 9'h000;
    end else if (boff) begin
      tec_reg <= tec_reg;
    end else if (i_evt.tx_err) begin
      tec_reg <= tec_reg + `CFE_TX_INC;
    end else if (i_evt.tx_ok && tec_reg != 9'h000) begin
      tec_reg <= tec_reg - 9'h001;
    end
  end

  // Receive count; saturates, falls back into range on success
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || i_cfg || recov_now) begin
      rec_reg <= 8'h00;
    end else if (boff) begin
      rec_reg <= rec_reg;
    end else if (i_evt.rx_err) begin
      rec_reg <= rec_sum[8] ? `CFE_BYTE_MAX : rec_sum[7:0];
    end else if (i_evt.rx_ok) begin
      if ({1'b0, rec_reg} > `CFE_CNT_PASS) begin
        rec_reg <= `CFE_REC_RET;
      end else if (rec_reg != 8'h00) begin
        rec_reg <= rec_reg - 8'h01;
      end
    end
  end

  // Counts recessive runs toward the end of bus-off
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !boff || recov_now) begin
      runs_reg <= 8'h00;
    end else if (i_evt.idle11) begin
      runs_reg <= runs_reg + 8'h01;
    end
  end

  // Recovery pulse
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      recov_reg <= 1'b0;
    end else begin
      recov_reg <= recov_now;
    end
  end

  assign o_fc     = {tec_reg, rec_reg};
  assign o_recov  = recov_reg;
endmodule

// ---- cfe_defines.svh ----
`ifndef CFE_DEFINES_SVH
`define CFE_DEFINES_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CFE_A_ERRCNT 8'h00
`define CFE_A_DIAG0  8'h04
`define CFE_A_DIAG1  8'h08
`define CFE_A_ISTAT  8'h0C
`define CFE_A_IMASK  8'h10
// ----------------------------------------
// Fault confinement limits and steps
// ----------------------------------------
`define CFE_TEC_BOFF 9'h0FF
`define CFE_CNT_PASS 9'h07F
`define CFE_CNT_WARN 9'h05F
`define CFE_CNT_WTOP 9'h080
`define CFE_TX_INC   9'h008
`define CFE_RX_SEV   9'h008
`define CFE_RX_ONE   9'h001
`define CFE_REC_RET  8'h77
`define CFE_RECOV_N  8'h7F
`define CFE_BYTE_MAX 8'hFF
// ----------------------------------------
// Field layouts
// ----------------------------------------
`define CFE_F_TEC   15:8
`define CFE_F_REC   7:0
`define CFE_F_UPPER 31:22
`define CFE_B_BO    21
`define CFE_B_TBP   20
`define CFE_B_RBP   19
`define CFE_B_TW    18
`define CFE_B_RW    17
`define CFE_B_EW    16
`define CFE_F_DTX   31:24
`define CFE_F_DRX   23:16
`define CFE_F_NTX   15:8
`define CFE_F_NRX   7:0
`define CFE_F_EFM   15:0
`define CFE_B_LEN   31
`define CFE_B_ESI   30
`define CFE_B_DBASE 24
`define CFE_B_BOFF  23
`define CFE_B_NBASE 16
`define CFE_B_NACK  18
`define CFE_D1_IMPL 32'hFBBF_FFFF
// ----------------------------------------
// Interrupt sources
// ----------------------------------------
`define CFE_IRQ_W   5
`define CFE_I_BOFF  0
`define CFE_I_RECOV 1
`define CFE_I_WARN  2
`define CFE_I_PASS  3
`define CFE_I_DIAG  4
`endif

// ---- cfe_irq.sv ----
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_irq (
  input  wire logic [`CFE_IRQ_W-1:0] i_clk_set, // Event pulses
  input  wire logic                  i_clk,     // Peripheral clock
  input  wire logic                  i_rst_n,   // Synchronous reset, active low
  input  wire logic                  i_stat_we, // Write-one-to-clear strobe
  input  wire logic                  i_mask_we, // Mask write strobe
  input  wire logic [`CFE_IRQ_W-1:0] i_wdata,   // Write data
  output logic      [`CFE_IRQ_W-1:0] o_stat,    // Sticky status
  output logic      [`CFE_IRQ_W-1:0] o_mask,    // Enable mask
  output logic                       o_irq      // Level interrupt
);
  logic [`CFE_IRQ_W-1:0] stat_reg; // Sticky status bits
  logic [`CFE_IRQ_W-1:0] mask_reg; // Mask bits
  logic                  irq_reg;  // Interrupt flop

  // Status: a new event wins over a clear in the same cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      stat_reg <= '0;
    end else begin
      stat_reg <= (stat_reg & ~(i_stat_we ? i_wdata : '0)) | i_clk_set;
    end
  end

  // Mask register
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_reg <= '0;
    end else if (i_mask_we) begin
      mask_reg <= i_wdata;
    end
  end

  // Interrupt level, high while an enabled bit is set
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  assign o_stat = stat_reg;
  assign o_mask = mask_reg;
  assign o_irq  = irq_reg;
endmodule

// ---- cfe_node_model.sv ----
`timescale 1ns/1ps
module cfe_node_model
  import cfe_pkg::*;
(
  input  wire logic i_clk, // Peripheral clock
  output cfe_evt_t  o_evt  // Event pulses toward the block
);
  initial o_evt = '0;
  // Back-to-back one-cycle pulses, then quiet
  task automatic send(input cfe_evt_t e, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge i_clk);
      o_evt <= e;
    end
    @(posedge i_clk);
    o_evt <= '0;
  endtask
endmodule

// ---- cfe_pkg.sv ----
package cfe_pkg;
  // Error kind; the order gives the flag offset within a phase group
  typedef enum logic [2:0] {
    CFE_K_BIT0, CFE_K_BIT1, CFE_K_ACK, CFE_K_FORM, CFE_K_STUFF, CFE_K_CRC
  } cfe_kind_t;
  // Events from the protocol engine, one-cycle pulses
  typedef struct packed {
    logic      tx_err;     // Transmit error detected
    logic      rx_err;     // Receive error detected
    logic      rx_sev;     // Receive error counts eight
    logic      tx_ok;      // Frame sent without error
    logic      rx_ok;      // Frame received without error
    logic      data_phase; // Error hit a data-rate bit
    cfe_kind_t kind;       // Kind of error
    logic      len_mm;     // Length code above payload size
    logic      esi;        // Received frame carries error state flag
    logic      idle11;     // Eleven recessive bits seen
  } cfe_evt_t;
  // Fault confinement state
  typedef struct packed {
    logic [8:0] tec;       // Transmit error count
    logic [7:0] rec;       // Receive error count
  } cfe_fc_t;
endpackage

// ---- cfe_top.sv ----
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "cfe_defines.svh"

module cfe_top
  import cfe_pkg::*;
(
  input  wire logic        I_MCLK,       // 200 MHz peripheral clock
  input  wire logic        I_RESETN,     // Synchronous reset, active low
  input  wire logic        I_CFG_MODE,   // Controller in configuration mode
  input  wire cfe_evt_t    I_EVT,        // Protocol engine events
  input  wire logic        I_WB_CYC,     // Bus cycle
  input  wire logic        I_WB_STB,     // Strobe
  input  wire logic        I_WB_WE,      // Write enable
  input  wire logic [7:0]  I_WB_ADR,     // Byte address
  input  wire logic [3:0]  I_WB_SEL,     // Byte lanes
  input  wire logic [31:0] I_WB_DAT,     // Write data
  output logic      [31:0] O_WB_DAT,     // Read data
  output logic             O_WB_ACK,     // Acknowledge
  output logic             O_IRQ,        // Interrupt level
  output logic             O_TX_BUS_OFF  // Transmitter bus-off state
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------

  // Expands byte selects into a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // Merges write data into a value under a lane mask
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [31:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  // Saturating byte increment
  function automatic logic [7:0] inc_sat(input logic [7:0] v, input logic en);
    inc_sat = (en && v != `CFE_BYTE_MAX) ? v + 8'h01 : v;
  endfunction

  // Passive and warning state of one count: {passive, warning}
  function automatic logic [1:0] cnt_state(input logic [8:0] c);
    cnt_state = {c > `CFE_CNT_PASS, (c > `CFE_CNT_WARN) && (c < `CFE_CNT_WTOP)};
  endfunction

  // Diagnostic flags raised by this cycle's events
  function automatic logic [31:0] flag_set(input cfe_evt_t e,
                                           input logic     boff,
                                           input logic     entry);
    int idx;
    flag_set = 32'h0000_0000;
    idx = (e.data_phase ? `CFE_B_DBASE : `CFE_B_NBASE) + int'(e.kind);
    if (e.tx_err || e.rx_err) begin
      if (e.kind == CFE_K_ACK) begin
        flag_set[`CFE_B_NACK] = 1'b1;
      end else begin
        flag_set[idx] = 1'b1;
      end
    end
    if (e.len_mm) begin
      flag_set[`CFE_B_LEN] = 1'b1;
    end
    if (e.esi) begin
      flag_set[`CFE_B_ESI] = 1'b1;
    end
    if (e.idle11 && boff) begin
      flag_set[`CFE_B_NBASE] = 1'b1;
    end
    if (entry) begin
      flag_set[`CFE_B_BOFF] = 1'b1;
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  cfe_fc_t                fc;            // Error counts
  logic                   recov;         // Recovery pulse
  logic                   bus_off;       // Transmit count above limit
  logic                   bo_flag;       // Bus-off status flag
  logic [1:0]             tx_st;         // Transmit passive and warning
  logic [1:0]             rx_st;         // Receive passive and warning
  logic                   any_warn;      // Either warning
  logic [7:0]             tec_view;      // Transmit count as read
  logic [31:0]            errcnt_val;    // Count register image
  logic                   boff_prev_reg; // Bus-off one cycle ago
  logic                   warn_prev_reg; // Warning one cycle ago
  logic                   pass_prev_reg; // Passive one cycle ago
  logic                   boff_entry;    // Bus-off just entered
  logic [31:0]            diag0_reg;     // Rate error counters
  logic [31:0]            diag0_next;    // Next rate error counters
  logic [31:0]            d0_base;       // Counters after any write
  logic [31:0]            diag1_reg;     // Flags and error-free count
  logic [31:0]            diag1_next;    // Next flags and count
  logic [31:0]            d1_base;       // Flags after any write
  logic [31:0]            fset;          // Flags raised now
  logic [`CFE_IRQ_W-1:0]  irq_set;       // Interrupt events
  logic [`CFE_IRQ_W-1:0]  istat;         // Interrupt status
  logic [`CFE_IRQ_W-1:0]  imask;         // Interrupt mask
  logic                   req;           // Bus request present
  logic [7:0]             adr_w;         // Word-aligned address
  logic [31:0]            wmask;         // Write lane mask
  logic                   wr_fire;       // Write takes effect now
  logic [31:0]            rd_mux;        // Read data selected
  logic                   ack_reg;       // Acknowledge flop
  logic [31:0]            dat_reg;       // Read data flop
  logic                   bo_out_reg;    // Bus-off output flop

  // ----------------------------------------
  // Fault confinement and status flags
  // ----------------------------------------
  cfe_confine u_confine (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RESETN),
    .i_cfg   (I_CFG_MODE),
    .i_evt   (I_EVT),
    .o_fc    (fc),
    .o_recov (recov)
  );

  assign bus_off  = fc.tec > `CFE_TEC_BOFF;
  assign bo_flag  = bus_off || I_CFG_MODE;
  assign tx_st    = cnt_state(fc.tec);
  assign rx_st    = cnt_state({1'b0, fc.rec});
  assign any_warn = tx_st[0] || rx_st[0];
  assign tec_view = bus_off ? `CFE_BYTE_MAX : fc.tec[7:0];

  // Count register image; upper bits stay zero
  always_comb begin
    errcnt_val              = 32'h0000_0000;
    errcnt_val[`CFE_B_BO]   = bo_flag;
    errcnt_val[`CFE_B_TBP]  = tx_st[1];
    errcnt_val[`CFE_B_RBP]  = rx_st[1];
    errcnt_val[`CFE_B_TW]   = tx_st[0];
    errcnt_val[`CFE_B_RW]   = rx_st[0];
    errcnt_val[`CFE_B_EW]   = any_warn;
    errcnt_val[`CFE_F_TEC]  = tec_view;
    errcnt_val[`CFE_F_REC]  = fc.rec;
  end

  // Previous state for entry detection
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      boff_prev_reg <= 1'b0;
      warn_prev_reg <= 1'b0;
      pass_prev_reg <= 1'b0;
    end else begin
      boff_prev_reg <= bus_off;
      warn_prev_reg <= any_warn;
      pass_prev_reg <= tx_st[1] || rx_st[1];
    end
  end

  assign boff_entry = bus_off && !boff_prev_reg;

  // Bus-off state to the protocol engine
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      bo_out_reg <= 1'b1;
    end else begin
      bo_out_reg <= bo_flag;
    end
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  assign req     = I_WB_CYC && I_WB_STB;
  assign adr_w   = {I_WB_ADR[7:2], 2'b00};
  assign wmask   = lanes(I_WB_SEL);
  assign wr_fire = req && I_WB_WE && ack_reg;

  // Read data selection; unmapped addresses read zero
  always_comb begin
    unique case (adr_w)
      `CFE_A_ERRCNT: rd_mux = errcnt_val;
      `CFE_A_DIAG0:  rd_mux = diag0_reg;
      `CFE_A_DIAG1:  rd_mux = diag1_reg;
      `CFE_A_ISTAT:  rd_mux = {{(32-`CFE_IRQ_W){1'b0}}, istat};
      `CFE_A_IMASK:  rd_mux = {{(32-`CFE_IRQ_W){1'b0}}, imask};
      default:       rd_mux = 32'h0000_0000;
    endcase
  end

  // Acknowledge one cycle after the request, dropped the next
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req && !ack_reg;
    end
  end

  // Read data captured with the request
  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      dat_reg <= 32'h0000_0000;
    end else if (req && !ack_reg) begin
      dat_reg <= rd_mux;
    end
  end

  // ----------------------------------------
  // Rate error counters
  // ----------------------------------------
  always_comb begin
    d0_base = (wr_fire && adr_w == `CFE_A_DIAG0) ?
              merge(diag0_reg, I_WB_DAT, wmask) : diag0_reg;
    diag0_next = d0_base;
    diag0_next[`CFE_F_DTX] = inc_sat(d0_base[`CFE_F_DTX],
                                     I_EVT.tx_err && I_EVT.data_phase);
    diag0_next[`CFE_F_DRX] = inc_sat(d0_base[`CFE_F_DRX],
                                     I_EVT.rx_err && I_EVT.data_phase);
    diag0_next[`CFE_F_NTX] = inc_sat(d0_base[`CFE_F_NTX],
                                     I_EVT.tx_err && !I_EVT.data_phase);
    diag0_next[`CFE_F_NRX] = inc_sat(d0_base[`CFE_F_NRX],
                                     I_EVT.rx_err && !I_EVT.data_phase);
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      diag0_reg <= 32'h0000_0000;
    end else begin
      diag0_reg <= diag0_next;
    end
  end

  // ----------------------------------------
  // Diagnostic flags and error-free count
  // ----------------------------------------
  assign fset = flag_set(I_EVT, bus_off, boff_entry);

  // A flag raised in the cycle of a write stays set
  always_comb begin
    d1_base = (wr_fire && adr_w == `CFE_A_DIAG1) ?
              merge(diag1_reg, I_WB_DAT, wmask) : diag1_reg;
    diag1_next = (d1_base & `CFE_D1_IMPL) | fset;
    diag1_next[`CFE_F_EFM] = d1_base[`CFE_F_EFM] +
                             {15'h0000, I_EVT.tx_ok || I_EVT.rx_ok};
  end

  always_ff @(posedge I_MCLK) begin
    if (!I_RESETN) begin
      diag1_reg <= 32'h0000_0000;
    end else begin
      diag1_reg <= diag1_next;
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_set              = '0;
    irq_set[`CFE_I_BOFF]  = boff_entry;
    irq_set[`CFE_I_RECOV] = recov;
    irq_set[`CFE_I_WARN]  = any_warn && !warn_prev_reg;
    irq_set[`CFE_I_PASS]  = (tx_st[1] || rx_st[1]) && !pass_prev_reg;
    irq_set[`CFE_I_DIAG]  = |fset;
  end

  cfe_irq u_irq (
    .i_clk_set (irq_set),
    .i_clk     (I_MCLK),
    .i_rst_n   (I_RESETN),
    .i_stat_we (wr_fire && adr_w == `CFE_A_ISTAT && I_WB_SEL[0]),
    .i_mask_we (wr_fire && adr_w == `CFE_A_IMASK && I_WB_SEL[0]),
    .i_wdata   (I_WB_DAT[`CFE_IRQ_W-1:0]),
    .o_stat    (istat),
    .o_mask    (imask),
    .o_irq     (O_IRQ)
  );

  assign O_WB_DAT     = dat_reg;
  assign O_WB_ACK     = ack_reg;
  assign O_TX_BUS_OFF = bo_out_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic rd_ec; // Count register read answered now
  assign rd_ec = O_WB_ACK && !I_WB_WE && adr_w == `CFE_A_ERRCNT;

  property p_boff;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      (fc.tec > `CFE_TEC_BOFF) |=> O_TX_BUS_OFF;
  endproperty
  a_boff: assert property (p_boff) else $error("bus-off not flagged");

  property p_cfg;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_CFG_MODE [*2] |-> O_TX_BUS_OFF;
  endproperty
  a_cfg: assert property (p_cfg) else $error("bus-off clear in config");

  property p_tbp;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec |-> O_WB_DAT[`CFE_B_TBP] == ($past(fc.tec) > `CFE_CNT_PASS);
  endproperty
  a_tbp: assert property (p_tbp) else $error("tx passive wrong");

  property p_rbp;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec |-> O_WB_DAT[`CFE_B_RBP] == ({1'b0, $past(fc.rec)} > `CFE_CNT_PASS);
  endproperty
  a_rbp: assert property (p_rbp) else $error("rx passive wrong");

  property p_tw;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec && O_WB_DAT[`CFE_B_TW] |-> $past(fc.tec) inside {[9'd96:9'd127]};
  endproperty
  a_tw: assert property (p_tw) else $error("tx warning out of range");

  property p_rw;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec && O_WB_DAT[`CFE_B_RW] |-> $past(fc.rec) inside {[8'd96:8'd127]};
  endproperty
  a_rw: assert property (p_rw) else $error("rx warning out of range");

  property p_ew;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec |-> O_WB_DAT[`CFE_B_EW] == (O_WB_DAT[`CFE_B_TW] || O_WB_DAT[`CFE_B_RW]);
  endproperty
  a_ew: assert property (p_ew) else $error("combined warning wrong");

  property p_zero;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      rd_ec |-> O_WB_DAT[`CFE_F_UPPER] == 10'h000;
  endproperty
  a_zero: assert property (p_zero) else $error("upper bits not zero");

  property p_nom;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_EVT.tx_err && !I_EVT.data_phase && !wr_fire &&
      diag0_reg[`CFE_F_NTX] != `CFE_BYTE_MAX
      |=> diag0_reg[`CFE_F_NTX] == $past(diag0_reg[`CFE_F_NTX]) + 8'h01;
  endproperty
  a_nom: assert property (p_nom) else $error("nominal count missed");

  property p_dat;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_EVT.rx_err && I_EVT.data_phase && !wr_fire
      |=> diag0_reg[`CFE_F_NRX] == $past(diag0_reg[`CFE_F_NRX]);
  endproperty
  a_dat: assert property (p_dat) else $error("data error counted nominal");

  property p_len;
    @(posedge I_MCLK) disable iff (!I_RESETN)
      I_EVT.len_mm |=> diag1_reg[`CFE_B_LEN];
  endproperty
  a_len: assert property (p_len) else $error("length flag missed");

  c_boff:  cover property (@(posedge I_MCLK) disable iff (!I_RESETN) boff_entry);
  c_recov: cover property (@(posedge I_MCLK) disable iff (!I_RESETN) recov);
  c_wr:    cover property (@(posedge I_MCLK) disable iff (!I_RESETN)
                           wr_fire && adr_w == `CFE_A_DIAG1);
  c_irq:   cover property (@(posedge I_MCLK) disable iff (!I_RESETN) O_IRQ);
endmodule

// ---- cfe_top_tb.sv ----
`timescale 1ns/1ps
`include "cfe_defines.svh"
module cfe_top_tb
  import cfe_pkg::*;
;
  localparam logic [31:0] F = 32'hFFFF_FFFF;
  logic        clk = 1'b0, rst_n = 1'b0, cfg = 1'b0; // Clock, reset, mode
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;    // Bus controls
  logic [3:0]  lane = 4'hF, sel = 4'hF;              // Lanes wanted, lanes driven
  logic [7:0]  adr = 8'h00;                          // Bus address
  logic [31:0] wdat = 32'h0, rdat, q;                // Bus data
  logic        ack, irq, boff;                       // Block outputs
  cfe_evt_t    evt;                                  // Event pulses
  int          failures = 0, checks_done = 0;        // Tallies
  always #2.5 clk = ~clk;
  cfe_node_model u_cfe_node_model (.i_clk(clk), .o_evt(evt));
  cfe_top u_cfe_top (.I_MCLK(clk), .I_RESETN(rst_n), .I_CFG_MODE(cfg), .I_EVT(evt),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(sel),
    .I_WB_DAT(wdat), .O_WB_DAT(rdat), .O_WB_ACK(ack), .O_IRQ(irq), .O_TX_BUS_OFF(boff));
  // Compare and tally
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Classic single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= lane;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 50) failures++;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q & m, e);
  endtask
  function automatic cfe_evt_t ev(input logic [5:0] t, input cfe_kind_t k, input logic [2:0] l);
    return cfe_evt_t'({t, k, l});
  endfunction
  task automatic finish_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    finish_test();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rc(`CFE_A_ERRCNT, F, 32'h0);
    cfg <= 1'b1;
    rc(`CFE_A_ERRCNT, F, 32'h0020_0000);
    chk({31'h0, boff}, 32'h1);
    cfg <= 1'b0;
    $display("reset and config test done");
    u_cfe_node_model.send(ev(6'h20, CFE_K_FORM, 3'h0), 12);
    rc(`CFE_A_ERRCNT, F, 32'h0005_6000);
    rc(`CFE_A_DIAG0, F, 32'h0000_0C00);
    rc(`CFE_A_DIAG1, 32'h0008_0000, 32'h0008_0000);
    u_cfe_node_model.send(ev(6'h20, CFE_K_FORM, 3'h0), 4);
    rc(`CFE_A_ERRCNT, F, 32'h0010_8000);
    u_cfe_node_model.send(ev(6'h20, CFE_K_FORM, 3'h0), 16);
    rc(`CFE_A_ERRCNT, F, 32'h0030_FF00);
    rc(`CFE_A_DIAG1, 32'h0080_0000, 32'h0080_0000);
    u_cfe_node_model.send(ev(6'h00, CFE_K_BIT0, 3'h1), 1);
    rc(`CFE_A_DIAG1, 32'h0001_0000, 32'h0001_0000);
    u_cfe_node_model.send(ev(6'h00, CFE_K_BIT0, 3'h1), 127);
    rc(`CFE_A_ERRCNT, F, 32'h0);
    chk({31'h0, boff}, 32'h0);
    $display("transmit states test done");
    u_cfe_node_model.send(ev(6'h19, CFE_K_CRC, 3'h0), 12);
    rc(`CFE_A_ERRCNT, F, 32'h0003_0060);
    rc(`CFE_A_DIAG0, 32'h00FF_0000, 32'h000C_0000);
    rc(`CFE_A_DIAG1, 32'h2000_0000, 32'h2000_0000);
    u_cfe_node_model.send(ev(6'h19, CFE_K_CRC, 3'h0), 4);
    rc(`CFE_A_ERRCNT, F, 32'h0008_0080);
    u_cfe_node_model.send(ev(6'h21, CFE_K_ACK, 3'h0), 1);
    u_cfe_node_model.send(ev(6'h00, CFE_K_BIT0, 3'h4), 1);
    u_cfe_node_model.send(ev(6'h04, CFE_K_BIT0, 3'h0), 2);
    rc(`CFE_A_DIAG1, 32'h8004_FFFF, 32'h8004_0002);
    $display("receive and flags test done");
    wb(1'b1, `CFE_A_DIAG0, 32'hA5A5_5A5A);
    rc(`CFE_A_DIAG0, F, 32'hA5A5_5A5A);
    lane = 4'h1;
    wb(1'b1, `CFE_A_DIAG0, 32'h0000_00C3);
    lane = 4'hF;
    rc(`CFE_A_DIAG0, F, 32'hA5A5_5AC3);
    wb(1'b1, `CFE_A_DIAG1, 32'h0);
    rc(`CFE_A_DIAG1, F, 32'h0);
    wb(1'b1, `CFE_A_ERRCNT, F);
    rc(`CFE_A_ERRCNT, F, 32'h0008_0680);
    rc(8'h40, F, 32'h0);
    $display("register access test done");
    wb(1'b1, `CFE_A_IMASK, 32'h1F);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    wb(1'b1, `CFE_A_ISTAT, 32'h1F);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, `CFE_A_IMASK, 32'h0);
    u_cfe_node_model.send(ev(6'h00, CFE_K_BIT0, 3'h4), 1);
    rc(`CFE_A_ISTAT, F, 32'h10);
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, `CFE_A_IMASK, 32'h10);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    $display("interrupt test done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk({31'h0, boff}, 32'h1);
    chk({31'h0, irq}, 32'h0);
    rst_n <= 1'b1;
    rc(`CFE_A_DIAG0, F, 32'h0);
    rc(`CFE_A_ERRCNT, F, 32'h0);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule
